// *** design/scs_cfg.svh ***
/*
  offsets, field positions, reset values and timing counts of the
  system clock select block; assumes inclusion by bare name only
*/
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

// register addresses on the special function register bus
`define SCS_CLOCK_SOURCE_SELECT_ADDR      8'h8F
`define SCS_EXTOSC_ADDR      8'hB6

// reset values
`define SCS_CLOCK_SOURCE_SELECT_RST       8'h00
`define SCS_EXTOSC_RST       8'h00

// clock_source_select fields
`define SCS_SRC_LSB          0
`define SCS_SRC_MSB          2
`define SCS_ODIV_LSB         4
`define SCS_ODIV_MSB         5

// external_oscillator_control fields
`define SCS_FRQ_LSB          0
`define SCS_FRQ_MSB          2
`define SCS_MODE_LSB         4
`define SCS_MODE_MSB         6
`define SCS_XVLD_BIT         7

// amplitude detector must stay good this many ref_clk cycles
`define SCS_XTAL_SETTLE_CYC  12'hFA0

`endif

// *** design/scs_pkg.sv ***
/*
  types shared by the system clock select block;
  assumes scs_cfg.svh for the numeric constants
*/
package scs_pkg;

  // system clock source codes
  typedef enum logic [2:0] {
    SCS_SRC_HFOSC = 3'b000,
    SCS_SRC_EXT   = 3'b001,
    SCS_SRC_LFOSC = 3'b010,
    SCS_SRC_PLL   = 3'b100
  } scs_src_t;

  // external oscillator modes
  typedef enum logic [2:0] {
    SCS_XM_OFF0   = 3'b000,
    SCS_XM_OFF1   = 3'b001,
    SCS_XM_CMOS   = 3'b010,
    SCS_XM_CMOS2  = 3'b011,
    SCS_XM_RC     = 3'b100,
    SCS_XM_CAP    = 3'b101,
    SCS_XM_XTAL   = 3'b110,
    SCS_XM_OSC_OUTPUT_PIN  = 3'b111
  } scs_xmode_t;

  // glitch-free switch states
  typedef enum logic [1:0] {
    SCS_MX_RUN   = 2'b00,
    SCS_MX_DRAIN = 2'b01,
    SCS_MX_ACQ   = 2'b10
  } scs_mux_st_t;

endpackage

// *** design/scs_div_if.sv ***
/*
  carrier between the top and one clock-level divider;
  assumes all levels are synchronous to ref_clk
*/
`timescale 1ns/1ps
interface scs_div_if;
  logic       src;   // input clock level
  logic [1:0] code;  // 00 /8, 01 /4, 10 /2, 11 /1
  logic       out;   // divided level, registered

  modport div (input src, input code, output out);
  modport user (output src, output code, input out);
endinterface

// *** design/scs_clk_div.sv ***
/*
  divides a sampled clock level by 8, 4, 2 or 1;
  assumes the level is synchronous to ref_clk
*/
`timescale 1ns/1ps
module scs_clk_div (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  scs_div_if.div    dv
);

  logic       prev_r;   // last sampled level
  logic       prev_nxt;
  logic [2:0] cnt_r;    // rising edge count
  logic [2:0] cnt_nxt;
  logic       out_r;    // registered output level
  logic       out_nxt;

  // next edge count and output tap
  always_comb begin
    prev_nxt = dv.src;
    cnt_nxt  = cnt_r + {2'h0, dv.src & ~prev_r};
    unique case (dv.code)
      2'b00: out_nxt = cnt_nxt[2];  // divide by 8
      2'b01: out_nxt = cnt_nxt[1];  // divide by 4
      2'b10: out_nxt = cnt_nxt[0];  // divide by 2
      2'b11: out_nxt = dv.src;      // straight through
    endcase
  end

  // state registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 1'b0;
      cnt_r  <= 3'h0;
      out_r  <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      cnt_r  <= cnt_nxt;
      out_r  <= out_nxt;
    end
  end

  assign dv.out = out_r;

endmodule // scs_clk_div

// *** design/scs_clk_select.sv ***
/*
  system clock source select and external oscillator control,
  with a glitch-free source mux and a divided clock output.
  assumes: oscillator levels sampled synchronously to ref_clk,
  a register port with address, write strobe and data, and the
  internal oscillator and pll controls kept outside this block
*/
`timescale 1ns/1ps
`include "scs_cfg.svh"

// Overview of operation
// - three-bit code picks system clock source
// - clock output divided by 1,2,4,8
// - select register resets to all zeros
// - select reserved bits read zero, write zero
// - crystal valid flag set once settled
// - external mode field decoded into eight modes
// - capacitor mode code selects k factor
// - external control bit 3 reads zero
// - external clock stays available for peripherals
// - source may change live when settled
// - internal oscillator selectable in same write
// - pll lock flag gates pll switch-over
// - crystal claims two pins, cmos rc and cap one, off none
// - rc and capacitor modes need no settling
// - high internal divider 8,4,2,1 per code
// - low internal divider 8,4,2,1 per code
module scs_clk_select (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        hf_osc_clk,
  input  wire logic        lf_osc_clk,
  input  wire logic        ext_osc_clk,
  input  wire logic        pll_clk,
  input  wire logic [1:0]  hf_internal_divider,
  input  wire logic [1:0]  lf_internal_divider,
  input  wire logic        pll_lock_flag,
  input  wire logic        xtal_amp_ok,
  output logic             system_clock,
  output logic             clk_out_pin,
  output logic             ext_periph_clk,
  output logic [2:0]       ext_osc_mode_code,
  output logic [2:0]       ext_osc_freq_range,
  output logic [17:0]      cap_kfactor_x100,
  output logic             osc_input_pin_claim,
  output logic             osc_output_pin_claim
);

  // divider lanes: 0 high internal, 1 low internal, 2 external, 3 clock out
  scs_div_if dv [4] ();

  logic [2:0]          src_sel_r;     // system_clock_source_code
  logic [2:0]          src_sel_nxt;
  logic [1:0]          odiv_r;        // clock_output_divider
  logic [1:0]          odiv_nxt;
  logic [2:0]          mode_r;        // ext_osc_mode_code
  logic [2:0]          mode_nxt;
  logic [2:0]          frq_r;         // ext_osc_freq_range
  logic [2:0]          frq_nxt;
  logic [11:0]         settle_r;      // crystal settle counter
  logic [11:0]         settle_nxt;
  logic                xvld_r;        // crystal_valid_flag
  logic                xvld_nxt;
  logic [7:0]          rdata_r;       // read data
  logic [7:0]          rdata_nxt;
  scs_pkg::scs_mux_st_t mx_st_r;      // switch state
  scs_pkg::scs_mux_st_t mx_st_nxt;
  logic [2:0]          cur_src_r;     // source driving system_clock now
  logic [2:0]          cur_src_nxt;
  logic                sys_r;         // system clock level
  logic                sys_nxt;
  logic                eclk_r;        // peripheral external clock
  logic                clko_r;        // clock output pin level
  logic [17:0]         kf_r;          // k factor, hundredths
  logic [17:0]         kf_nxt;
  logic                pin_in_r;      // input pin taken over
  logic                pin_out_r;     // output pin taken over
  logic                ext_en;        // external circuit on
  logic                xtal_mode;     // crystal modes 11x
  logic                wr_sel;        // write to select register
  logic                wr_ext;        // write to external control

  // level of a source code; reserved codes give low
  function automatic logic src_level(input logic [2:0] code, input logic [3:0] lv);
    unique case (code)
      scs_pkg::SCS_SRC_HFOSC: src_level = lv[0];
      scs_pkg::SCS_SRC_EXT:   src_level = lv[1];
      scs_pkg::SCS_SRC_LFOSC: src_level = lv[2];
      scs_pkg::SCS_SRC_PLL:   src_level = lv[3];
      default:                src_level = 1'b0;
    endcase
  endfunction

  // a code the mux may take over; pll only when locked
  function automatic logic src_ok(input logic [2:0] code, input logic lock);
    unique case (code)
      scs_pkg::SCS_SRC_HFOSC,
      scs_pkg::SCS_SRC_EXT,
      scs_pkg::SCS_SRC_LFOSC: src_ok = 1'b1;
      scs_pkg::SCS_SRC_PLL:   src_ok = lock;
      default:                src_ok = 1'b0;
    endcase
  endfunction

  // divider lanes share one module
  for (genvar i = 0; i < 4; i++) begin : g_div
    scs_clk_div u_div (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .dv      (dv[i])
    );
  end

  assign ext_en    = (mode_r[2:1] != 2'b00);
  assign xtal_mode = (mode_r[2:1] == 2'b11);
  assign wr_sel    = sfr_wr && (sfr_addr == `SCS_CLOCK_SOURCE_SELECT_ADDR);
  assign wr_ext    = sfr_wr && (sfr_addr == `SCS_EXTOSC_ADDR);

  assign dv[0].src  = hf_osc_clk;
  assign dv[0].code = hf_internal_divider;
  assign dv[1].src  = lf_osc_clk;
  assign dv[1].code = lf_internal_divider;
  assign dv[2].src  = ext_osc_clk & ext_en;
  // cmos/2 and crystal/2 halve; the others pass straight through
  assign dv[2].code = (mode_r[1] & mode_r[0]) ? 2'b10 : 2'b11;
  assign dv[3].src  = sys_r;
  // code order of the output divider is the reverse of the lane's
  assign dv[3].code = ~odiv_r;

  // register writes; reserved bits never stored
  always_comb begin
    src_sel_nxt = src_sel_r;
    odiv_nxt    = odiv_r;
    mode_nxt    = mode_r;
    frq_nxt     = frq_r;
    if (wr_sel) begin
      src_sel_nxt = sfr_wdata[`SCS_SRC_MSB:`SCS_SRC_LSB];
      odiv_nxt    = sfr_wdata[`SCS_ODIV_MSB:`SCS_ODIV_LSB];
    end
    if (wr_ext) begin
      mode_nxt = sfr_wdata[`SCS_MODE_MSB:`SCS_MODE_LSB];
      frq_nxt  = sfr_wdata[`SCS_FRQ_MSB:`SCS_FRQ_LSB];
    end
  end

  // crystal settle: amplitude must hold for the whole count
  always_comb begin
    settle_nxt = settle_r;
    xvld_nxt   = xvld_r;
    if (!xtal_mode || !xtal_amp_ok) begin
      settle_nxt = 12'h000;
      xvld_nxt   = 1'b0;
    end else if (settle_r == `SCS_XTAL_SETTLE_CYC) begin
      xvld_nxt   = 1'b1;
    end else begin
      settle_nxt = settle_r + 12'h001;
    end
  end

  // registered read data, one cycle after the address
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (sfr_addr)
      `SCS_CLOCK_SOURCE_SELECT_ADDR: rdata_nxt = {2'h0, odiv_r, 1'b0, src_sel_r};
      `SCS_EXTOSC_ADDR: rdata_nxt = {xvld_r, mode_r, 1'b0, frq_r};
      default:          rdata_nxt = 8'h00;
    endcase
  end

  // glitch-free switch: drain old source low, then wait new low
  always_comb begin
    mx_st_nxt   = mx_st_r;
    cur_src_nxt = cur_src_r;
    sys_nxt     = 1'b0;
    unique case (mx_st_r)
      scs_pkg::SCS_MX_RUN: begin
        sys_nxt = src_level(cur_src_r, {pll_clk, dv[1].out, dv[2].out, dv[0].out});
        // reserved codes keep the running source
        if (src_sel_r != cur_src_r && src_ok(src_sel_r, 1'b1)) begin
          mx_st_nxt = scs_pkg::SCS_MX_DRAIN;
        end
      end
      scs_pkg::SCS_MX_DRAIN: begin
        // hold output at its level until the old clock falls
        sys_nxt = sys_r & src_level(cur_src_r, {pll_clk, dv[1].out, dv[2].out, dv[0].out});
        if (!sys_nxt) begin
          mx_st_nxt = scs_pkg::SCS_MX_ACQ;
        end
      end
      scs_pkg::SCS_MX_ACQ: begin
        // low output until the new source is low and usable
        if (!src_level(src_sel_r, {pll_clk, dv[1].out, dv[2].out, dv[0].out}) &&
            src_ok(src_sel_r, pll_lock_flag)) begin
          cur_src_nxt = src_sel_r;
          mx_st_nxt   = scs_pkg::SCS_MX_RUN;
        end
      end
      default: mx_st_nxt = scs_pkg::SCS_MX_RUN;
    endcase
  end

  // capacitor k factor, only meaningful in capacitor mode
  always_comb begin
    unique case (frq_r)
      3'b000: kf_nxt = 18'h00057;
      3'b001: kf_nxt = 18'h00104;
      3'b010: kf_nxt = 18'h00302;
      3'b011: kf_nxt = 18'h00898;
      3'b100: kf_nxt = 18'h01964;
      3'b101: kf_nxt = 18'h04650;
      3'b110: kf_nxt = 18'h10360;
      3'b111: kf_nxt = 18'h26D18;
    endcase
  end

  // all state registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_sel_r <= 3'(`SCS_CLOCK_SOURCE_SELECT_RST);
      odiv_r    <= 2'(`SCS_CLOCK_SOURCE_SELECT_RST >> `SCS_ODIV_LSB);
      mode_r    <= 3'(`SCS_EXTOSC_RST >> `SCS_MODE_LSB);
      frq_r     <= 3'(`SCS_EXTOSC_RST);
      settle_r  <= 12'h000;
      xvld_r    <= 1'b0;
      rdata_r   <= 8'h00;
      mx_st_r   <= scs_pkg::SCS_MX_RUN;
      cur_src_r <= 3'h0;
      sys_r     <= 1'b0;
      eclk_r    <= 1'b0;
      clko_r    <= 1'b0;
      kf_r      <= 18'h00000;
      pin_in_r  <= 1'b0;
      pin_out_r <= 1'b0;
    end else begin
      src_sel_r <= src_sel_nxt;
      odiv_r    <= odiv_nxt;
      mode_r    <= mode_nxt;
      frq_r     <= frq_nxt;
      settle_r  <= settle_nxt;
      xvld_r    <= xvld_nxt;
      rdata_r   <= rdata_nxt;
      mx_st_r   <= mx_st_nxt;
      cur_src_r <= cur_src_nxt;
      sys_r     <= sys_nxt;
      eclk_r    <= dv[2].out;
      clko_r    <= dv[3].out;
      kf_r      <= kf_nxt;
      pin_in_r  <= xtal_mode;
      pin_out_r <= ext_en;
    end
  end

  assign sfr_rdata            = rdata_r;
  assign system_clock         = sys_r;
  assign clk_out_pin          = clko_r;
  assign ext_periph_clk       = eclk_r;
  assign ext_osc_mode_code    = mode_r;
  assign ext_osc_freq_range   = frq_r;
  assign cap_kfactor_x100     = kf_r;
  assign osc_input_pin_claim  = pin_in_r;
  assign osc_output_pin_claim = pin_out_r;

endmodule // scs_clk_select

// *** tb/scs_clk_select_properties.sv ***
/*
  concurrent checks on the clock select top ports;
  assumes a bind onto scs_clk_select and one ref_clk domain
*/
`timescale 1ns/1ps
module scs_clk_select_checker (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        xtal_amp_ok,
  input wire logic [2:0]  ext_osc_mode_code,
  input wire logic [2:0]  ext_osc_freq_range,
  input wire logic [17:0] cap_kfactor_x100,
  input wire logic        osc_input_pin_claim,
  input wire logic        osc_output_pin_claim
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // k factor in hundredths per range code
  localparam logic [17:0] KF [8] = '{18'h00057, 18'h00104, 18'h00302, 18'h00898,
                                     18'h01964, 18'h04650, 18'h10360, 18'h26D18};
  logic [11:0] amp_cnt_r;  // cycles of good amplitude in crystal mode
  // saturating, so a long wait never wraps back below the settle figure
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      amp_cnt_r <= 12'h000;
    else if (!xtal_amp_ok || ext_osc_mode_code[2:1] != 2'h3)
      amp_cnt_r <= 12'h000;
    else if (amp_cnt_r != 12'hFFF)
      amp_cnt_r <= amp_cnt_r + 12'h001;
  end
  sequence s_xwr;
    sfr_wr && sfr_addr == 8'hB6;
  endsequence
  a_mode_write: assert property (s_xwr |=> ext_osc_mode_code == $past(sfr_wdata[6:4]))
    else $error("mode field missed a write");
  a_freq_write: assert property (s_xwr |=> ext_osc_freq_range == $past(sfr_wdata[2:0]))
    else $error("range field missed a write");
  a_sel_reserved: assert property ($past(sfr_addr) == 8'h8F |-> (sfr_rdata & 8'hC8) == 8'h00)
    else $error("select reserved bits read nonzero");
  a_xctl_bit3: assert property ($past(sfr_addr) == 8'hB6 |-> !sfr_rdata[3])
    else $error("control bit 3 read nonzero");
  // read data lags the flag and the flag lags the count, one cycle each
  a_valid_settle: assert property ($past(sfr_addr) == 8'hB6 && sfr_rdata[7] |-> $past(amp_cnt_r, 2) > 12'hF9F)
    else $error("valid flag before settling");
  a_in_claim: assert property ($stable(ext_osc_mode_code) [*2] |->
    osc_input_pin_claim == (ext_osc_mode_code[2:1] == 2'h3))
    else $error("input pin claim wrong");
  a_out_claim: assert property ($stable(ext_osc_mode_code) [*2] |->
    osc_output_pin_claim == (ext_osc_mode_code[2:1] != 2'h0))
    else $error("output pin claim wrong");
  a_cap_kfactor: assert property (ext_osc_mode_code == 3'h5 && $stable(ext_osc_freq_range) [*2] |->
    cap_kfactor_x100 == KF[ext_osc_freq_range])
    else $error("k factor wrong");
endmodule // scs_clk_select_checker

bind scs_clk_select scs_clk_select_checker u_chk (
  .ref_clk, .rst_b, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .xtal_amp_ok, .ext_osc_mode_code,
  .ext_osc_freq_range, .cap_kfactor_x100, .osc_input_pin_claim, .osc_output_pin_claim
);

// *** tb/scs_xosc_model.sv ***
/*
  external oscillator model: clock level of period 6 and an amplitude
  detector; assumes the mode code from the block's output
*/
`timescale 1ns/1ps
module scs_xosc_model #(
  parameter int SETTLE = 4100  // settle cycles, far shorter than a real crystal
) (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic [2:0] mode,
  output logic           osc_clk,
  output logic           amp_ok
);
  logic [1:0]  ph_r;  // phase within half period
  logic [12:0] st_r;  // cycles since crystal mode began
  // circuit off holds the clock still; rc and cap run at once
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_r    <= 2'h0;
      osc_clk <= 1'b0;
      st_r    <= 13'h0000;
    end else begin
      if (mode[2:1] == 2'h0) begin
        ph_r    <= 2'h0;
        osc_clk <= 1'b0;
      end else if (ph_r == 2'h2) begin
        ph_r    <= 2'h0;
        osc_clk <= !osc_clk;
      end else
        ph_r <= ph_r + 2'h1;
      if (mode[2:1] != 2'h3)
        st_r <= 13'h0000;
      else if (st_r < SETTLE)
        st_r <= st_r + 13'h0001;
    end
  end
  assign amp_ok = (mode[2:1] == 2'h3) && (st_r >= SETTLE);
endmodule // scs_xosc_model

// *** tb/test_scs_clk_select.sv ***
/*
  self-checking bench for the clock select block;
  assumes the checker is bound in and the oscillator model
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_scs_clk_select;
  logic ref_clk = 1'b0, rst_b, sfr_wr, pll_lock_flag, xtal_amp_ok, ext_osc_clk;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [1:0] hf_internal_divider, lf_internal_divider;
  logic [2:0] osc_cnt = 3'h0, ext_osc_mode_code;  // internal and pll levels
  logic system_clock, clk_out_pin, ext_periph_clk;
  int num_errors = 0, num_checks = 0, cyc = 0;
  always #4 ref_clk = !ref_clk;
  always @(posedge ref_clk) osc_cnt <= osc_cnt + 3'h1;
  scs_clk_select u_dut (.ref_clk, .rst_b, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
    .hf_osc_clk(osc_cnt[0]), .lf_osc_clk(osc_cnt[1]), .ext_osc_clk, .pll_clk(osc_cnt[2]),
    .hf_internal_divider, .lf_internal_divider, .pll_lock_flag, .xtal_amp_ok, .system_clock,
    .clk_out_pin, .ext_periph_clk, .ext_osc_mode_code, .ext_osc_freq_range(),
    .cap_kfactor_x100(), .osc_input_pin_claim(), .osc_output_pin_claim());
  scs_xosc_model u_osc (.ref_clk, .rst_b, .mode(ext_osc_mode_code), .osc_clk(ext_osc_clk),
    .amp_ok(xtal_amp_ok));
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, about twice the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      results();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wr <= 1'b1;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    sfr_addr <= a;
    repeat (3) @(posedge ref_clk);
    #1 `CHK("rdata", e, sfr_rdata)
  endtask
  // rising edges in 480 cycles; phase allows one edge either way
  task automatic meas(input int es, input int eo, input int ep);
    int n[3];
    logic [2:0] p, c;
    n = '{0, 0, 0};
    repeat (60) @(posedge ref_clk);
    #1 p = {system_clock, clk_out_pin, ext_periph_clk};
    repeat (480) begin
      @(posedge ref_clk);
      #1 c = {system_clock, clk_out_pin, ext_periph_clk};
      for (int i = 0; i < 3; i++) n[i] += int'(c[2-i] && !p[2-i]);
      p = c;
    end
    foreach (n[i]) if (n[i] - (i == 0 ? es : i == 1 ? eo : ep) inside {-1, 1}) n[i] -= n[i] - (i == 0 ? es : i == 1 ? eo : ep);
    `CHK("system_clock rises", es, n[0])
    `CHK("clkout rises", eo, n[1])
    `CHK("periph rises", ep, n[2])
  endtask
  initial begin
    {rst_b, sfr_wr, pll_lock_flag, sfr_addr, sfr_wdata} = '0;
    {hf_internal_divider, lf_internal_divider} = 4'h0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(8'h8F, 8'h00);
    rd(8'hB6, 8'h00);
    rd(8'h55, 8'h00);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk) hf_internal_divider <= 2'(k);
      meas(30 << k, 30 << k, 0);
    end
    for (int d = 0; d < 4; d++) begin
      wr(8'h8F, {2'h0, 2'(d), 4'h0});
      meas(240, 240 >> d, 0);
    end
    wr(8'h8F, 8'h37);
    rd(8'h8F, 8'h37);
    meas(240, 30, 0);
    $display("select and divider tests done");
    wr(8'h8F, 8'h02);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk) lf_internal_divider <= 2'(k);
      meas(15 << k, 15 << k, 0);
    end
    wr(8'hB6, 8'h20);
    wr(8'h8F, 8'h01);
    meas(80, 80, 80);
    wr(8'hB6, 8'h30);
    meas(40, 40, 40);
    wr(8'h8F, 8'h00);
    meas(240, 240, 40);
    wr(8'h8F, 8'h04);
    meas(0, 0, 40);
    @(posedge ref_clk) pll_lock_flag <= 1'b1;
    meas(60, 60, 40);
    wr(8'h8F, 8'h00);
    $display("source switch tests done");
    for (int m = 0; m < 8; m++) begin
      wr(8'hB6, {1'b1, 3'(m), 1'b1, 3'(m)});
      rd(8'hB6, {1'b0, 3'(m), 1'b0, 3'(m)});
    end
    for (int f = 0; f < 8; f++) begin
      wr(8'hB6, {4'h5, 1'b0, 3'(f)});
      rd(8'hB6, {4'h5, 1'b0, 3'(f)});
    end
    wr(8'hB6, 8'h40);
    meas(240, 240, 80);
    wr(8'hB6, 8'h67);
    repeat (4000) @(posedge ref_clk);
    rd(8'hB6, 8'h67);
    repeat (4300) @(posedge ref_clk);
    rd(8'hB6, 8'hE7);
    wr(8'hB6, 8'h47);
    rd(8'hB6, 8'h47);
    $display("external oscillator tests done");
    results();
  end
endmodule // test_scs_clk_select
